//--- shared/remap_pkg.sv
// Constants, field layouts and types for the remote target address remap table.
// Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
package remap_pkg;
    localparam int NUM_SLOTS = 5;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;
    localparam int I2C_ADDR_W = 7;
    localparam int SLOT_NUM_W = 3;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [IDX_W-1:0] PHYS_IDX_SLOT1 = 8'h3a;
    localparam logic [IDX_W-1:0] PHYS_IDX_SLOT2 = 8'h3b;
    localparam logic [IDX_W-1:0] PHYS_IDX_SLOT3 = 8'h3c;
    localparam logic [IDX_W-1:0] PHYS_IDX_SLOT4 = 8'h3d;
    localparam logic [IDX_W-1:0] PHYS_IDX_SLOT5 = 8'h3e;
    localparam logic [IDX_W-1:0] PHYS_IDX [NUM_SLOTS] = '{
        PHYS_IDX_SLOT1, PHYS_IDX_SLOT2, PHYS_IDX_SLOT3, PHYS_IDX_SLOT4, PHYS_IDX_SLOT5
    };
    localparam logic [IDX_W-1:0] ALIAS_IDX [NUM_SLOTS] = '{
        8'h50, 8'h51, 8'h52, 8'h53, 8'h54
    };
    localparam logic [IDX_W-1:0] CTRL_IDX = 8'h58;
    localparam logic [IDX_W-1:0] STATUS_IDX = 8'h59;
    localparam logic [IDX_W-1:0] MISS_IDX = 8'h5a;

    // Address fields sit in bits 7:1 of the slot registers; bit 0 reads zero.
    localparam int ADDR_FIELD_MSB = 7;
    localparam int ADDR_FIELD_LSB = 1;
    localparam logic [I2C_ADDR_W-1:0] PHYS_RESET = 7'h00;
    localparam logic [I2C_ADDR_W-1:0] ALIAS_RESET = 7'h00;
    localparam logic [I2C_ADDR_W-1:0] ALIAS_OFF = 7'h00;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    localparam int STAT_SLOT_LSB = 0;
    localparam int STAT_HIT_BIT = 3;
    localparam int STAT_ADDR_LSB = 4;
    localparam int STAT_ENABLE_BIT = 11;
    localparam int STAT_COUNT_LSB = 16;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
endpackage

//--- shared/slot_cfg_if.sv
// Bundle between the remap table and one slot: register writes, contents and the match.
// Assumes the owner drives the query address and write strobes on the same clock.
interface slot_cfg_if;
    logic wr_phys;
    logic wr_alias;
    logic [remap_pkg::I2C_ADDR_W-1:0] wdata;
    logic [remap_pkg::I2C_ADDR_W-1:0] query;
    logic [remap_pkg::I2C_ADDR_W-1:0] phys;
    logic [remap_pkg::I2C_ADDR_W-1:0] alias_addr;
    logic hit;

    modport owner (
        output wr_phys,
        output wr_alias,
        output wdata,
        output query,
        input phys,
        input alias_addr,
        input hit
    );

    modport slot (
        input wr_phys,
        input wr_alias,
        input wdata,
        input query,
        output phys,
        output alias_addr,
        output hit
    );
endinterface

//--- hdl/remap_slot.sv
// One remap slot: the alias decoder address, the physical target address and the match.
// Assumes write strobes are single-cycle pulses from the register bus on clk_i.
module remap_slot (
    input wire logic clk_i,
    input wire logic rst_i,
    slot_cfg_if.slot cfg
);
    logic [remap_pkg::I2C_ADDR_W-1:0] phys;
    logic [remap_pkg::I2C_ADDR_W-1:0] alias_addr;
    logic [remap_pkg::I2C_ADDR_W-1:0] next_phys;
    logic [remap_pkg::I2C_ADDR_W-1:0] next_alias_addr;

    always_comb begin
        next_phys = phys;
        next_alias_addr = alias_addr;
        if (cfg.wr_phys) begin
            next_phys = cfg.wdata;
        end
        if (cfg.wr_alias) begin
            next_alias_addr = cfg.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phys <= remap_pkg::PHYS_RESET;
            alias_addr <= remap_pkg::ALIAS_RESET;
        end else begin
            phys <= next_phys;
            alias_addr <= next_alias_addr;
        end
    end

    // A cleared alias disables the slot, so an all-zero query never reaches the target.
    assign cfg.hit = (alias_addr != remap_pkg::ALIAS_OFF) && (alias_addr == cfg.query);
    assign cfg.phys = phys;
    assign cfg.alias_addr = alias_addr;
endmodule

//--- hdl/remap_table.sv
// Remote target address remap table for slots 1 to 5, with a Wishbone register slave.
// Assumes a classic Wishbone master on clk_i and a local I2C front end on the same clock.
// Notes on behaviour
// - alias match forwards with slot's physical address.
// - physical address in bits 7:1, read/write.
// - physical address fields reset to zero.
// - slots 1..5 at consecutive indices 0x3a..0x3e.
// - zero alias never matches any transaction.
//
// Decided for this implementation: the Wishbone register port.
module remap_table #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [remap_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic req_valid_i,
    input wire logic req_read_i,
    input wire logic [remap_pkg::I2C_ADDR_W-1:0] req_addr_i,
    output logic fwd_valid_o,
    output logic fwd_read_o,
    output logic [remap_pkg::I2C_ADDR_W-1:0] fwd_addr_o,
    output logic [remap_pkg::SLOT_NUM_W-1:0] fwd_slot_o,
    output logic miss_o,
    output logic [remap_pkg::NUM_SLOTS-1:0] slot_hit_o
);
    localparam int N = remap_pkg::NUM_SLOTS;
    localparam int AW = remap_pkg::I2C_ADDR_W;
    localparam int SW = remap_pkg::SLOT_NUM_W;

    slot_cfg_if cfg [N] ();

    logic [N-1:0] hit_vec;
    logic [N-1:0] wr_phys_vec;
    logic [N-1:0] wr_alias_vec;
    logic [AW-1:0] phys_vec [N];
    logic [AW-1:0] alias_vec [N];
    logic [AW-1:0] wdata_field;

    for (genvar k = 0; k < N; k++) begin : g_slot
        assign cfg[k].wr_phys = wr_phys_vec[k];
        assign cfg[k].wr_alias = wr_alias_vec[k];
        assign cfg[k].wdata = wdata_field;
        assign cfg[k].query = req_addr_i;
        assign hit_vec[k] = cfg[k].hit;
        assign phys_vec[k] = cfg[k].phys;
        assign alias_vec[k] = cfg[k].alias_addr;

        remap_slot u_slot (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg(cfg[k])
        );
    end

    // Register bus slave.
    remap_pkg::bus_state_t state;
    remap_pkg::bus_state_t next_state;
    logic next_ack;
    logic [31:0] next_rdata;
    logic [remap_pkg::IDX_W-1:0] idx;
    logic bus_req;
    logic addr_ok;
    logic wr_lane;
    logic wr_ctrl;
    logic enable;
    logic next_enable;
    logic clear_pulse;

    assign idx = wb_adr_i[remap_pkg::ADDR_W-1:2];
    assign addr_ok = (wb_adr_i[1:0] == 2'b00);
    assign bus_req = wb_cyc_i && wb_stb_i && (state == remap_pkg::BUS_IDLE);
    // Every writable field lives in the low byte, so a write without lane 0 changes nothing.
    assign wr_lane = bus_req && addr_ok && wb_we_i && wb_sel_i[0];
    assign wdata_field = wb_dat_i[remap_pkg::ADDR_FIELD_MSB:remap_pkg::ADDR_FIELD_LSB];
    assign wr_ctrl = wr_lane && (idx == remap_pkg::CTRL_IDX);
    assign clear_pulse = wr_ctrl && wb_dat_i[remap_pkg::CTRL_CLEAR_BIT];

    always_comb begin
        for (int k = 0; k < N; k++) begin
            wr_phys_vec[k] = wr_lane && (idx == remap_pkg::PHYS_IDX[k]);
            wr_alias_vec[k] = wr_lane && (idx == remap_pkg::ALIAS_IDX[k]);
        end
    end

    // Status and counters.
    logic [SW-1:0] last_slot;
    logic last_hit;
    logic [AW-1:0] last_addr;
    logic [CNT_W-1:0] fwd_count;
    logic [CNT_W-1:0] miss_count;
    logic [SW-1:0] next_last_slot;
    logic next_last_hit;
    logic [AW-1:0] next_last_addr;
    logic [CNT_W-1:0] next_fwd_count;
    logic [CNT_W-1:0] next_miss_count;
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[remap_pkg::STAT_SLOT_LSB +: SW] = last_slot;
        status_word[remap_pkg::STAT_HIT_BIT] = last_hit;
        status_word[remap_pkg::STAT_ADDR_LSB +: AW] = last_addr;
        status_word[remap_pkg::STAT_ENABLE_BIT] = enable;
        status_word[remap_pkg::STAT_COUNT_LSB +: CNT_W] = fwd_count;
    end

    always_comb begin
        next_state = state;
        next_ack = 1'b0;
        next_rdata = 32'h0000_0000;
        next_enable = enable;
        if (wr_ctrl) begin
            next_enable = wb_dat_i[remap_pkg::CTRL_ENABLE_BIT];
        end
        unique case (state)
            remap_pkg::BUS_IDLE: begin
                if (bus_req) begin
                    next_state = remap_pkg::BUS_ACK;
                    next_ack = 1'b1;
                    // Unmapped or misaligned addresses answer with zero data.
                    if (addr_ok && !wb_we_i) begin
                        for (int k = 0; k < N; k++) begin
                            if (idx == remap_pkg::PHYS_IDX[k]) begin
                                next_rdata[remap_pkg::ADDR_FIELD_MSB:remap_pkg::ADDR_FIELD_LSB] =
                                    phys_vec[k];
                            end
                            if (idx == remap_pkg::ALIAS_IDX[k]) begin
                                next_rdata[remap_pkg::ADDR_FIELD_MSB:remap_pkg::ADDR_FIELD_LSB] =
                                    alias_vec[k];
                            end
                        end
                        if (idx == remap_pkg::CTRL_IDX) begin
                            next_rdata[remap_pkg::CTRL_ENABLE_BIT] = enable;
                        end
                        if (idx == remap_pkg::STATUS_IDX) begin
                            next_rdata = status_word;
                        end
                        if (idx == remap_pkg::MISS_IDX) begin
                            next_rdata[CNT_W-1:0] = miss_count;
                        end
                    end
                end
            end
            remap_pkg::BUS_ACK: begin
                next_state = remap_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= remap_pkg::BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            enable <= remap_pkg::CTRL_ENABLE_RESET;
        end else begin
            state <= next_state;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_rdata;
            enable <= next_enable;
        end
    end

    // Address translation: the lowest matching slot wins if aliases overlap.
    logic found;
    logic [SW-1:0] sel_slot;
    logic [AW-1:0] sel_phys;
    logic next_fwd_valid;
    logic next_fwd_read;
    logic [AW-1:0] next_fwd_addr;
    logic [SW-1:0] next_fwd_slot;
    logic next_miss;
    logic [N-1:0] next_slot_hit;

    always_comb begin
        found = 1'b0;
        sel_slot = '0;
        sel_phys = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (hit_vec[k]) begin
                found = 1'b1;
                sel_slot = SW'(k + 1);
                sel_phys = phys_vec[k];
            end
        end
    end

    always_comb begin
        next_fwd_valid = 1'b0;
        next_fwd_read = fwd_read_o;
        next_fwd_addr = fwd_addr_o;
        next_fwd_slot = fwd_slot_o;
        next_miss = 1'b0;
        next_slot_hit = '0;
        next_last_slot = last_slot;
        next_last_hit = last_hit;
        next_last_addr = last_addr;
        next_fwd_count = clear_pulse ? '0 : fwd_count;
        next_miss_count = clear_pulse ? '0 : miss_count;
        if (req_valid_i) begin
            if (enable && found) begin
                next_fwd_valid = 1'b1;
                next_fwd_read = req_read_i;
                next_fwd_addr = sel_phys;
                next_fwd_slot = sel_slot;
                next_slot_hit = hit_vec;
                next_last_slot = sel_slot;
                next_last_hit = 1'b1;
                next_last_addr = sel_phys;
                // A forward in the clearing cycle is still counted.
                next_fwd_count = next_fwd_count + CNT_W'(1);
            end else begin
                next_miss = 1'b1;
                next_last_hit = 1'b0;
                next_miss_count = next_miss_count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_valid_o <= 1'b0;
            fwd_read_o <= 1'b0;
            fwd_addr_o <= '0;
            fwd_slot_o <= '0;
            miss_o <= 1'b0;
            slot_hit_o <= '0;
            last_slot <= '0;
            last_hit <= 1'b0;
            last_addr <= '0;
            fwd_count <= '0;
            miss_count <= '0;
        end else begin
            fwd_valid_o <= next_fwd_valid;
            fwd_read_o <= next_fwd_read;
            fwd_addr_o <= next_fwd_addr;
            fwd_slot_o <= next_fwd_slot;
            miss_o <= next_miss;
            slot_hit_o <= next_slot_hit;
            last_slot <= next_last_slot;
            last_hit <= next_last_hit;
            last_addr <= next_last_addr;
            fwd_count <= next_fwd_count;
            miss_count <= next_miss_count;
        end
    end

    // Checks on the table and the bus answer.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_remap_slot1: assert property (
        (req_valid_i && enable && hit_vec[0])
        |=> (fwd_valid_o && fwd_slot_o == 3'h1 && fwd_addr_o == $past(phys_vec[0])))
        else $error("slot 1 alias hit not forwarded with its physical address");

    a_phys_readback: assert property (
        (wb_ack_o && !wb_we_i && wb_adr_i == {remap_pkg::PHYS_IDX_SLOT1, 2'b00})
        |-> (wb_dat_o[7:1] == phys_vec[0] && wb_dat_o[0] == 1'b0 && wb_dat_o[31:8] == 24'h0))
        else $error("slot 1 physical address reads back wrong");

    a_phys_write: assert property (
        (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == {remap_pkg::PHYS_IDX_SLOT3, 2'b00})
        |=> (phys_vec[2] == $past(wb_dat_i[7:1]) && wb_ack_o))
        else $error("slot 3 physical address write lost");

    a_reset_zero: assert property (
        disable iff (1'b0)
        $past(rst_i) |-> (phys_vec[0] == 7'h00 && phys_vec[4] == 7'h00 && phys_vec[2] == 7'h00))
        else $error("physical address not zero after reset");

    a_slot5_top: assert property (
        (wb_ack_o && !wb_we_i && wb_adr_i == {remap_pkg::PHYS_IDX_SLOT5, 2'b00})
        |-> (wb_dat_o[7:1] == phys_vec[4]))
        else $error("slot 5 not at the highest index");

    // Looking at the hit vector rather than the slot number catches a zero alias that
    // matches while a lower slot wins the priority.
    a_alias_zero: assert property (
        (req_valid_i && alias_vec[1] == 7'h00)
        |=> !slot_hit_o[1])
        else $error("slot 2 forwarded with a zero alias");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    a_ack_latency: assert property (
        (bus_req) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not given one cycle after the request");

    c_forward: cover property (req_valid_i && enable && found ##1 fwd_valid_o);
    c_miss: cover property (req_valid_i ##1 miss_o);
    c_write_then_read: cover property (wr_phys_vec[0] ##[1:20] (wb_ack_o && !wb_we_i));
    c_overlap: cover property (req_valid_i && hit_vec[0] && hit_vec[4]);
endmodule

//--- tb/fwd_sink.sv
// Far-side model of the control channel: logs every forwarded request and every miss.
// Assumes the remap table answers each request with a one-cycle pulse on clk_i.
module fwd_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fwd_valid_i,
    input wire logic fwd_read_i,
    input wire logic [remap_pkg::I2C_ADDR_W-1:0] fwd_addr_i,
    input wire logic [remap_pkg::SLOT_NUM_W-1:0] fwd_slot_i,
    input wire logic miss_i,
    input wire logic [remap_pkg::NUM_SLOTS-1:0] slot_hit_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] log_q [$];

    // A miss is logged without address fields, since those hold stale values then.
    always @(posedge clk_i) begin
        if (rst_i) begin
            log_q.delete();
        end else if (fwd_valid_i) begin
            log_q.push_back({1'b0, fwd_read_i, slot_hit_i, fwd_slot_i, fwd_addr_i});
        end else if (miss_i) begin
            log_q.push_back(17'h10000);
        end
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the remap table: Wishbone register tasks and translation requests.
// Assumes one 100 MHz clock and the far-side log kept by fwd_sink.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cyc, stb, we, ack, req_valid, req_read;
    logic fwd_valid, fwd_read, miss;
    logic [9:0] adr;
    logic [31:0] wdat, rdat, rd;
    logic [3:0] sel;
    logic [6:0] req_addr, fwd_addr;
    logic [2:0] fwd_slot;
    logic [4:0] slot_hit;
    int n_fail = 0;
    int n_checks = 0;
    localparam logic [16:0] MISS_E = 17'h10000;

    remap_table uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .req_valid_i(req_valid), .req_read_i(req_read), .req_addr_i(req_addr),
        .fwd_valid_o(fwd_valid), .fwd_read_o(fwd_read), .fwd_addr_o(fwd_addr),
        .fwd_slot_o(fwd_slot), .miss_o(miss), .slot_hit_o(slot_hit));
    fwd_sink sink (.clk_i(clk), .rst_i(rst), .fwd_valid_i(fwd_valid), .fwd_read_i(fwd_read),
        .fwd_addr_i(fwd_addr), .fwd_slot_i(fwd_slot), .miss_i(miss), .slot_hit_i(slot_hit));

    function automatic logic [6:0] phys_of(input int k);
        return 7'h20 + 7'(k * 3);
    endfunction
    function automatic logic [6:0] alias_of(input int k);
        return 7'h40 + 7'(k);
    endfunction
    function automatic logic [16:0] hit_e(input int k, input logic r, input logic [6:0] p);
        return {1'b0, r, 5'(1 << (k - 1)), 3'(k), p};
    endfunction

    task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", name, e, g);
            n_fail++;
        end
    endtask

    // The request is held until ack is seen high at a rising edge, or until 50 further cycles pass.
    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        sel <= s;
        @(posedge clk);
        while (ack !== 1'b1 && t < 50) begin
            @(posedge clk);
            t++;
        end
        q = rdat;
        if (t >= 50) begin
            $display("MISMATCH wb_ack_o expected 1 seen timeout");
            n_fail++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'hf, q);
    endtask

    task automatic rd_check(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 32'h00000000, 4'hf, q);
        check($sformatf("register %h", idx), e, q);
    endtask

    task automatic send(input logic [6:0] a, input logic r);
        req_valid <= 1'b1;
        req_addr <= a;
        req_read <= r;
        @(posedge clk);
    endtask

    task automatic idle_req;
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic log_check(input logic [16:0] e);
        logic [16:0] g;
        g = 17'h1ffff;
        if (sink.log_q.size() > 0) g = sink.log_q.pop_front();
        check("forward", {15'h0000, e}, {15'h0000, g});
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        $display("MISMATCH watchdog expected done seen hang");
        n_fail++;
        summarize;
    end

    initial begin
        {rst, cyc, stb, we, req_valid, req_read} = 6'b100000;
        adr = 10'h000;
        wdat = 32'h00000000;
        sel = 4'h0;
        req_addr = 7'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 1; k <= 5; k++) rd_check(8'h39 + 8'(k), 32'h00000000);
        $display("test reset_values done");
        for (int k = 1; k <= 5; k++) wr(8'h39 + 8'(k), {24'h000000, phys_of(k), 1'b1});
        for (int k = 1; k <= 5; k++) rd_check(8'h39 + 8'(k), {24'h0, phys_of(k), 1'b0});
        wb(1'b1, 8'h3a, 32'h000000fe, 4'h0, rd);
        rd_check(8'h3a, {24'h000000, phys_of(1), 1'b0});
        rd_check(8'h3f, 32'h00000000);
        $display("test slot_registers done");
        send(7'h00, 1'b0);
        idle_req();
        log_check(MISS_E);
        for (int k = 1; k <= 5; k++) wr(remap_pkg::ALIAS_IDX[k-1], {24'h0, alias_of(k), 1'b0});
        for (int k = 1; k <= 5; k++) send(alias_of(k), 1'(k));
        idle_req();
        for (int k = 1; k <= 5; k++) log_check(hit_e(k, 1'(k), phys_of(k)));
        wr(8'h3b, {24'h000000, 7'h7f, 1'b0});
        send(alias_of(2), 1'b1);
        idle_req();
        log_check(hit_e(2, 1'b1, 7'h7f));
        $display("test translation done");
        // A slot whose alias returns to zero must drop out even though its old alias is sent.
        wr(remap_pkg::ALIAS_IDX[2], 32'h00000000);
        send(alias_of(3), 1'b0);
        send(7'h00, 1'b1);
        idle_req();
        log_check(MISS_E);
        log_check(MISS_E);
        $display("test zero_alias done");
        // A disabled table must miss even on a live alias; the clear restarts both counts.
        wr(remap_pkg::CTRL_IDX, 32'h00000000);
        send(alias_of(1), 1'b0);
        idle_req();
        log_check(MISS_E);
        rd_check(remap_pkg::MISS_IDX, 32'h00000004);
        rd_check(remap_pkg::STATUS_IDX, 32'h000607f2);
        wr(remap_pkg::CTRL_IDX, 32'h00000003);
        rd_check(remap_pkg::CTRL_IDX, 32'h00000001);
        rd_check(remap_pkg::MISS_IDX, 32'h00000000);
        send(alias_of(1), 1'b1);
        idle_req();
        log_check(hit_e(1, 1'b1, phys_of(1)));
        rd_check(remap_pkg::STATUS_IDX, 32'h00010a39);
        $display("test control_status done");
        summarize;
    end
endmodule
